/* File: logic/smcd_top.sv */
/*
 * Control decoder of an eight-input, two-output mixer: serial shift
 * register, address/data byte decode, channel enable and attenuation
 * banks, global silence, daisy-chain output, and an APB window.
 * Assumes the serial pins come from outside the pclk domain and toggle
 * no faster than a few pclk periods per phase.
 */
// Overview of operation
// - Sample serial input on rising serial clock
// - Silence input high mutes every channel
// - Silence keeps all stored settings intact
// - Silence acts without any serial clock edge
// - Attenuation 0 to 63 dB, 1 dB steps
// - Separate left and right enables per channel
// - Two banks of eight channel registers
// - Attenuation registers are six bits wide
// - Address write latches the selected channel
// - Address write updates that channel's enables
// - Data write loads attenuation of selected channel
// - Repeated data writes hit same channel
// - MSB high means address, low means data
// - Shift while write low; load on strobe rise
// - Chain output shows shift register MSB
`timescale 1ns/1ps
module smcd_top
   import smcd_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link pins
   input  wire logic        serial_clk,
   input  wire logic        serial_in,
   input  wire logic        write_n,
   input  wire logic        load_strobe,
   output logic             chain_out,
   // Global silence pin
   input  wire logic        silence,
   // Mixer controls to the analog section
   output logic [NUM_CH-1:0] left_on,
   output logic [NUM_CH-1:0] right_on,
   output logic [NUM_CH*ATTEN_W-1:0] atten
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic                s_clk, s_in, s_wr_n, s_load, s_mute;
   logic [2:0]          last;
   logic [BYTE_W-1:0]   shift;
   logic [CH_W-1:0]     sel_ch;
   logic [NUM_CH-1:0]   en_left, en_right;
   logic [ATTEN_W-1:0]  att [NUM_CH];
   logic [31:0]         ctrl;
   logic                clk_rise, load_rise, is_addr;
   logic                apb_wr, apb_rd;
   logic [31:0]         next_rdata;
   logic                next_err;

   // Channel index from an attenuation register address
   function automatic logic [CH_W-1:0] att_index(input logic [11:0] a);
      logic [11:0] d;
      d = a - OFF_ATT0;
      return d[CH_W+1:2];
   endfunction

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   smcd_sync u_sclk (.clk(pclk), .rst_n(presetn),
                     .async_in(serial_clk),  .sync_out(s_clk));
   smcd_sync u_sin  (.clk(pclk), .rst_n(presetn),
                     .async_in(serial_in),   .sync_out(s_in));
   smcd_sync u_wr   (.clk(pclk), .rst_n(presetn),
                     .async_in(write_n),     .sync_out(s_wr_n));
   smcd_sync u_ld   (.clk(pclk), .rst_n(presetn),
                     .async_in(load_strobe), .sync_out(s_load));
   smcd_sync u_mute (.clk(pclk), .rst_n(presetn),
                     .async_in(silence),     .sync_out(s_mute));

   // Edge history of synchronised clock and strobe; bit 2 is spare
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= RST_SYNC;
      end else begin
         last <= {1'b0, s_load, s_clk};
      end
   end

   assign clk_rise  = s_clk & ~last[0];
   assign load_rise = s_load & ~last[1];
   assign is_addr   = shift[POS_KIND];

   // ***************************************************************
   // Serial shift register
   // ***************************************************************
   // Shifts MSB first, only while write is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift <= RST_SHIFT;
      end else if (clk_rise && !s_wr_n) begin
         shift <= {shift[BYTE_W-2:0], s_in};
      end
   end

   // Chain output follows the MSB one pclk after it changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_out <= 1'b0;
      end else begin
         chain_out <= shift[BYTE_W-1];
      end
   end

   // ***************************************************************
   // Register banks
   // ***************************************************************
   // Selected channel; the device itself has no reset, bench uses one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_ch <= '0;
      end else if (load_rise && is_addr) begin
         sel_ch <= shift[POS_CH_LO +: CH_W];
      end
   end

   // Enable bank, written only by address bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_left  <= '0;
         en_right <= '0;
      end else if (load_rise && is_addr) begin
         en_left[shift[POS_CH_LO +: CH_W]]  <= shift[POS_LEFT];
         en_right[shift[POS_CH_LO +: CH_W]] <= shift[POS_RIGHT];
      end
   end

   // Attenuation bank; silence never touches it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            att[i] <= '0;
         end
      end else if (load_rise && !is_addr) begin
         att[sel_ch] <= shift[POS_ATT_LO +: ATTEN_W];
      end
   end

   // ***************************************************************
   // Mixer outputs
   // ***************************************************************
   // Silence gates the outputs only, so stored state survives.
   // The async set path mutes without waiting for any clock edge;
   // release is synchronised to avoid a runt at the switches.
   always_ff @(posedge pclk or posedge silence) begin
      if (silence) begin
         left_on  <= '0;
         right_on <= '0;
      end else if (s_mute) begin
         left_on  <= '0;
         right_on <= '0;
      end else begin
         left_on  <= en_left;
         right_on <= en_right;
      end
   end

   // Attenuation codes, one field per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atten <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            atten[i*ATTEN_W +: ATTEN_W] <= att[i];
         end
      end
   end

   // ***************************************************************
   // APB slave
   // ***************************************************************
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~pwrite;

   // Scratch control word, steers nothing in the analog path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= RST_CTRL;
      end else if (apb_wr && paddr == OFF_CTRL) begin
         ctrl <= pwdata;
      end
   end

   // Read decode
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (paddr == OFF_CTRL) begin
         next_rdata = ctrl;
      end else if (paddr == OFF_STATUS) begin
         next_rdata = {24'h00_0000, s_mute, 1'b0, sel_ch[2:0], shift[2:0]};
      end else if (paddr == OFF_LEFT) begin
         next_rdata = {24'h00_0000, en_left};
      end else if (paddr == OFF_RIGHT) begin
         next_rdata = {24'h00_0000, en_right};
      end else if (paddr >= OFF_ATT0 && paddr <= OFF_ATT7
                   && paddr[1:0] == 2'b00) begin
         next_rdata = {26'h000_0000, att[att_index(paddr)]};
      end else begin
         next_err   = 1'b1;
      end
   end

   // No wait state: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         if (apb_rd && !penable) begin
            prdata <= next_rdata;
         end
      end
   end

endmodule

/* File: logic/smcd_pkg.sv */
/*
 * Shared constants of the serial mixer control decoder: byte layout,
 * channel count, attenuation width and register bus map.
 * Assumes nothing of its surroundings.
 */
package smcd_pkg;

   // ***************************************************************
   // Serial byte layout
   // ***************************************************************
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned NUM_CH     = 8;
   localparam int unsigned CH_W       = 3;
   localparam int unsigned ATTEN_W    = 6;
   localparam int unsigned POS_KIND   = 7;
   localparam int unsigned POS_LEFT   = 6;
   localparam int unsigned POS_RIGHT  = 5;
   localparam int unsigned POS_CH_LO  = 0;
   localparam int unsigned POS_ATT_LO = 0;

   // ***************************************************************
   // Register bus map (byte addresses)
   // ***************************************************************
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_LEFT   = 12'h008;
   localparam logic [11:0] OFF_RIGHT  = 12'h00c;
   localparam logic [11:0] OFF_ATT0   = 12'h010;
   localparam logic [11:0] OFF_ATT7   = 12'h02c;

   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
   localparam logic [7:0]  RST_SHIFT  = 8'h00;
   localparam logic [2:0]  RST_SYNC   = 3'h0;

endpackage

/* File: logic/smcd_sync.sv */
/*
 * Two-flip-flop synchroniser for one level from another domain.
 * Assumes the level is slow against the destination clock.
 */
`timescale 1ns/1ps
module smcd_sync
   import smcd_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

/* File: sim/smcd_asserts.sv */
/* Port checker of the mixer decoder top.
   Assumes it is bound to smcd_top and sees its ports only. */
`timescale 1ns/1ps
module smcd_asserts
   import smcd_pkg::*;
(
   // Clock, reset and bus
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic [11:0]               paddr,
   input  wire logic                      pready,
   input  wire logic                      pslverr,
   // Pins and mixer controls
   input  wire logic                      serial_clk,
   input  wire logic                      load_strobe,
   input  wire logic                      chain_out,
   input  wire logic                      silence,
   input  wire logic [NUM_CH-1:0]         left_on,
   input  wire logic [NUM_CH-1:0]         right_on,
   input  wire logic [NUM_CH*ATTEN_W-1:0] atten
);
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_MUTE: assert property (
      silence |-> left_on == '0 && right_on == '0)
      else $error("switch closed while silenced");
   AST_ATT_MUTE: assert property (
      $rose(silence) |=> $stable(atten) [*3])
      else $error("silence altered attenuation");
   // Bank update needs at most five cycles after a strobe rise
   AST_ATT_LOAD: assert property (
      (!$rose(load_strobe)) [*8] |-> $stable(atten))
      else $error("attenuation moved without strobe");
   AST_CHAIN: assert property (
      $stable(serial_clk) [*6] |-> $stable(chain_out))
      else $error("chain output moved without clock");
   AST_READY_ANS: assert property (
      psel && !penable |=> pready)
      else $error("no answer in access cycle");
   AST_READY_ONE: assert property (
      pready |=> !pready)
      else $error("ready held too long");
   AST_ERR_MAP: assert property (
      pready |-> pslverr == (paddr > 12'h02c))
      else $error("error flag against map");
   AST_ERR_REQ: assert property (
      pslverr |-> pready)
      else $error("error flag without ready");
endmodule
bind smcd_top smcd_asserts i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .serial_clk(serial_clk),
   .load_strobe(load_strobe), .chain_out(chain_out),
   .silence(silence), .left_on(left_on), .right_on(right_on),
   .atten(atten));

/* File: sim/smcd_host.sv */
/* Host model driving the serial link of the mixer decoder.
   Assumes its task is called just after a rising pclk edge. */
`timescale 1ns/1ps
module smcd_host (
   // Clock
   input  wire logic pclk,
   // Serial link
   output logic      serial_clk,
   output logic      serial_in,
   output logic      write_n,
   output logic      load_strobe
);
   // Clock stands still low between frames
   initial begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      write_n = 1'b1;
      load_strobe = 1'b1;
   end
   // One byte; phases of three cycles keep the pin syncs happy
   task automatic send(input logic [7:0] b, input logic en);
      int k;
      write_n <= !en;
      load_strobe <= 1'b0;
      for (k = 7; k >= 0; k--) begin
         serial_in <= b[k];
         repeat (3) @(posedge pclk);
         serial_clk <= 1'b1;
         repeat (3) @(posedge pclk);
         serial_clk <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      write_n <= 1'b1;
      load_strobe <= 1'b1;
      serial_in <= ~b[0]; // Released line, not the last bit
      repeat (3) @(posedge pclk);
   endtask
endmodule

/* File: sim/serial_mixer_control_decoder_tb.sv */
/* Self-checking bench of the mixer decoder.
   Assumes smcd_top, smcd_host and the bound checker. */
`timescale 1ns/1ps
module serial_mixer_control_decoder_tb
   import smcd_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic serial_clk, serial_in, write_n, load_strobe, chain_out, silence;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, rng;
   logic [7:0]  left_on, right_on;
   logic [47:0] atten;
   logic        el[8], er[8], e;
   logic [5:0]  ea[8];
   logic [2:0]  sel;
   int          num_errors, num_checks;
   smcd_top i_smcd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_clk(serial_clk),
      .serial_in(serial_in), .write_n(write_n),
      .load_strobe(load_strobe), .chain_out(chain_out),
      .silence(silence), .left_on(left_on), .right_on(right_on),
      .atten(atten));
   smcd_host i_smcd_host (.pclk(pclk), .serial_clk(serial_clk),
      .serial_in(serial_in), .write_n(write_n),
      .load_strobe(load_strobe));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [47:0] fa();
      for (int i = 0; i < 8; i++) fa[6*i +: 6] = ea[i];
   endfunction
   function automatic logic [7:0] fl(input logic r);
      for (int i = 0; i < 8; i++) fl[i] = r ? er[i] : el[i];
   endfunction
   task automatic chk(input string n, input logic [47:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bus cycle; idle edge first so no signal is driven twice at once
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look mid-cycle; the request stands until the edge that sees ready
      n = 0;
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20) begin @(negedge pclk); n++; end
      q = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin num_errors++; wrap_up(); end
   endtask
   // Byte to the device plus the expected bank update
   task automatic put(input logic [7:0] b, input logic en = 1'b1);
      i_smcd_host.send(b, en);
      if (en && b[7]) begin
         sel = b[2:0]; el[sel] = b[6]; er[sel] = b[5];
      end else if (en) ea[sel] = b[5:0];
      repeat (8) @(posedge pclk);
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; silence = 1'b1; rng = 32'habf3d3ed;
      num_errors = 0; num_checks = 0; sel = '0;
      for (int i = 0; i < 8; i++) begin el[i]=0; er[i]=0; ea[i]=0; end
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // All channels set up while silenced, ignored address bits random
      for (int i = 0; i < 8; i++) begin
         rng = lfsr(rng); put({1'b1, rng[6:3], 3'(i)});
         rng = lfsr(rng); put({2'b00, rng[5:0]});
      end
      chk("atten", atten, fa());
      chk("muted", {left_on, right_on}, '0);
      silence <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("left", left_on, fl(0));
      chk("right", right_on, fl(1));
      apb(0, OFF_LEFT, '0);
      chk("left reg", q[7:0], fl(0));
      apb(0, OFF_STATUS, '0);
      chk("status", {q[7], q[5:3]}, {1'b0, sel});
      $display("test config done");
      // Fade one channel with boundary codes
      put(8'hc2);
      chk("chain", chain_out, 1'b1);
      for (int k = 0; k < 3; k++) begin
         rng = lfsr(rng);
         put(k == 0 ? 8'h3f : k == 1 ? 8'h00 : {2'b00, rng[5:0]});
         chk("fade", atten, fa());
      end
      // Clocks with write high must not shift
      put(8'h9f, 1'b0);
      chk("gated", {chain_out, atten}, {1'b0, fa()});
      $display("test fade done");
      // Silence with no pclk edge in between
      silence <= 1'b1;
      #1 chk("async", left_on, '0);
      repeat (4) @(posedge pclk);
      silence <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("restore", left_on, fl(0));
      rng = lfsr(rng);
      apb(1, OFF_CTRL, rng);
      apb(0, OFF_CTRL, '0);
      chk("scratch", q, rng);
      apb(0, 12'h100, '0);
      chk("unmapped", {e, q}, {1'b1, 32'h0});
      $display("test bus done");
      wrap_up();
   end
endmodule
